/* File: inc/dmba_regs.vh */
`ifndef DMBA_REGS_VH
`define DMBA_REGS_VH

// register map, byte addresses
`define DMBA_OFS_CTRL 4'h0
`define DMBA_OFS_STATUS 4'h4
`define DMBA_OFS_LAST 4'h8

// control register fields
`define DMBA_CTRL_BEF 0
`define DMBA_CTRL_BSEL_LO 4
`define DMBA_CTRL_STK_BANK 8
`define DMBA_CTRL_CLR_STICKY 9

// reset values
`define DMBA_RST_BEF 1'h0
`define DMBA_RST_BSEL 4'h0
`define DMBA_RST_STK_BANK 1'h0

// banks and decode windows
`define DMBA_BANK_LOW 4'h0
`define DMBA_BANK_HIGH 4'hF
`define DMBA_RAM_LAST 12'h0FF
`define DMBA_PERIPH_FIRST 12'hF80
`define DMBA_FMEM_INTR 4'hB
`define DMBA_FMEM_PORT 4'hF

// addressing modes
`define DMBA_MODE_DIR1 4'h0
`define DMBA_MODE_DIR4 4'h1
`define DMBA_MODE_DIR8 4'h2
`define DMBA_MODE_MAIN 4'h3
`define DMBA_MODE_MAIN_INC 4'h4
`define DMBA_MODE_MAIN_DEC 4'h5
`define DMBA_MODE_ALT 4'h6
`define DMBA_MODE_MIXED 4'h7
`define DMBA_MODE_MAIN8 4'h8
`define DMBA_MODE_FMEM 4'h9
`define DMBA_MODE_PMEM 4'hA
`define DMBA_MODE_HMEM 4'hB
`define DMBA_MODE_STACK 4'hC

// instruction classes
`define DMBA_OP_MOVE 4'h0
`define DMBA_OP_EXCH 4'h1
`define DMBA_OP_INC_SKIP 4'h2
`define DMBA_OP_IN 4'h3
`define DMBA_OP_OUT 4'h4
`define DMBA_OP_SET 4'h5
`define DMBA_OP_CLR 4'h6
`define DMBA_OP_SKIP_TRUE 4'h7
`define DMBA_OP_SKIP_FALSE 4'h8
`define DMBA_OP_OTHER 4'h9

`endif

/* File: rtl/dmba_addr_gen.v */
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`include "dmba_regs.vh"

module dmba_addr_gen #(
  parameter SAVE_DEPTH = 8,
  parameter SAVE_AW = 3
) (
  sys_clk,
  rst,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  req_valid,
  req_mode,
  req_class,
  operand,
  bit_idx,
  ptr_h,
  ptr_l,
  ptr_d,
  ptr_e,
  stack_ptr,
  bank_enable_set,
  bank_enable_clr,
  bank_sel_wr,
  bank_sel_val,
  call_enter,
  call_return,
  intr_enter,
  intr_vector_bef,
  intr_return,
  mem_addr_q,
  bit_sel_q,
  addr_valid_q,
  pair_access_q,
  ram_sel_q,
  periph_sel_q,
  mode_err_q,
  ptr_l_wr_q,
  ptr_l_next_q,
  bank_enable_flag_q,
  bank_select_reg_q
);
  input wire sys_clk;
  input wire rst;
  input wire [3:0] reg_addr;
  input wire [31:0] reg_wdata;
  input wire reg_wr;
  input wire reg_rd;
  output reg [31:0] reg_rdata;
  input wire req_valid;
  input wire [3:0] req_mode;
  input wire [3:0] req_class;
  input wire [7:0] operand;
  input wire [1:0] bit_idx;
  input wire [3:0] ptr_h;
  input wire [3:0] ptr_l;
  input wire [3:0] ptr_d;
  input wire [3:0] ptr_e;
  input wire [7:0] stack_ptr;
  input wire bank_enable_set;
  input wire bank_enable_clr;
  input wire bank_sel_wr;
  input wire [3:0] bank_sel_val;
  input wire call_enter;
  input wire call_return;
  input wire intr_enter;
  input wire intr_vector_bef;
  input wire intr_return;
  output reg [11:0] mem_addr_q;
  output reg [1:0] bit_sel_q;
  output reg addr_valid_q;
  output reg pair_access_q;
  output reg ram_sel_q;
  output reg periph_sel_q;
  output reg mode_err_q;
  output reg ptr_l_wr_q;
  output reg [3:0] ptr_l_next_q;
  output reg bank_enable_flag_q;
  output reg [3:0] bank_select_reg_q;

  reg stack_bank_select_q;
  reg [SAVE_DEPTH-1:0] save_stack_q;
  reg [SAVE_AW:0] save_cnt_q;
  reg save_ovf_q;
  reg save_unf_q;
  reg err_seen_q;

  // bank resolution
  reg [3:0] bank_direct;
  reg [3:0] bank_and;
  reg [11:0] addr_d;
  reg [1:0] bit_d;
  reg pair_d;
  reg err_d;
  reg ptr_wr_d;
  reg [3:0] ptr_next_d;
  reg bef_d;
  reg bef_pop;
  wire ctrl_wr;
  wire bsel_ok;
  wire sw_bsel_ok;
  wire save_full;
  wire save_empty;
  wire [3:0] sw_bsel;
  wire status_wr;
  wire sticky_clr;
  wire addr_in_ram;
  wire addr_in_periph;
  wire [3:0] save_depth;
  wire [31:0] ctrl_word;
  wire [31:0] status_word;
  // slot count at which every save slot is taken
  localparam [SAVE_AW:0] SAVE_FULL_CNT = SAVE_DEPTH[SAVE_AW:0];

  assign ctrl_wr = reg_wr && (reg_addr == `DMBA_OFS_CTRL);
  assign sw_bsel = reg_wdata[`DMBA_CTRL_BSEL_LO+3:`DMBA_CTRL_BSEL_LO];
  // any other bank value is dropped, the register keeps its old contents
  assign bsel_ok = (bank_sel_val == `DMBA_BANK_LOW) ||
                   (bank_sel_val == `DMBA_BANK_HIGH);
  assign sw_bsel_ok = (sw_bsel == `DMBA_BANK_LOW) ||
                      (sw_bsel == `DMBA_BANK_HIGH);
  assign save_full = (save_cnt_q == SAVE_FULL_CNT);
  assign save_empty = (save_cnt_q == {(SAVE_AW+1){1'b0}});
  assign status_wr = reg_wr && (reg_addr == `DMBA_OFS_STATUS);
  // overflow and underflow are cleared together by one control write
  assign sticky_clr = ctrl_wr && reg_wdata[`DMBA_CTRL_CLR_STICKY];
  assign addr_in_ram = (addr_d <= `DMBA_RAM_LAST);
  assign addr_in_periph = (addr_d >= `DMBA_PERIPH_FIRST);
  // the status field is four bits wide, enough for the default depth
  assign save_depth = save_cnt_q[3:0];
  assign ctrl_word = {23'h0, stack_bank_select_q, bank_select_reg_q,
                      3'h0, bank_enable_flag_q};
  assign status_word = {20'h0, save_depth, 5'h0, save_unf_q, save_ovf_q,
                        err_seen_q};

  always @* begin
    if (bank_enable_flag_q) begin
      bank_direct = bank_select_reg_q;
    end else if (operand[7]) begin
      bank_direct = `DMBA_BANK_HIGH;
    end else begin
      bank_direct = `DMBA_BANK_LOW;
    end
    bank_and = bank_select_reg_q & {4{bank_enable_flag_q}};
  end

  // address formation, purely on present values
  always @* begin
    addr_d = {bank_direct, operand};
    bit_d = bit_idx;
    pair_d = 1'b0;
    err_d = 1'b0;
    ptr_wr_d = 1'b0;
    ptr_next_d = ptr_l;
    case (req_mode)
      `DMBA_MODE_DIR1: begin
        err_d = !((req_class == `DMBA_OP_SET) ||
                  (req_class == `DMBA_OP_CLR) ||
                  (req_class == `DMBA_OP_SKIP_TRUE) ||
                  (req_class == `DMBA_OP_SKIP_FALSE));
      end
      `DMBA_MODE_DIR4: begin
        err_d = !((req_class == `DMBA_OP_MOVE) ||
                  (req_class == `DMBA_OP_EXCH) ||
                  (req_class == `DMBA_OP_INC_SKIP) ||
                  (req_class == `DMBA_OP_IN) ||
                  (req_class == `DMBA_OP_OUT));
      end
      `DMBA_MODE_DIR8: begin
        addr_d = {bank_direct, operand[7:1], 1'b0};
        pair_d = 1'b1;
        err_d = operand[0] ||
                !((req_class == `DMBA_OP_MOVE) ||
                  (req_class == `DMBA_OP_EXCH) ||
                  (req_class == `DMBA_OP_IN) ||
                  (req_class == `DMBA_OP_OUT));
      end
      `DMBA_MODE_MAIN: begin
        addr_d = {bank_and, ptr_h, ptr_l};
      end
      `DMBA_MODE_MAIN_INC: begin
        addr_d = {bank_and, ptr_h, ptr_l};
        ptr_wr_d = 1'b1;
        ptr_next_d = ptr_l + 4'h1;
      end
      `DMBA_MODE_MAIN_DEC: begin
        addr_d = {bank_and, ptr_h, ptr_l};
        ptr_wr_d = 1'b1;
        ptr_next_d = ptr_l - 4'h1;
      end
      `DMBA_MODE_ALT: begin
        addr_d = {`DMBA_BANK_LOW, ptr_d, ptr_e};
      end
      `DMBA_MODE_MIXED: begin
        addr_d = {`DMBA_BANK_LOW, ptr_d, ptr_l};
      end
      `DMBA_MODE_MAIN8: begin
        // bit 0 of the low nibble is forced clear to pick the even word
        addr_d = {bank_and, ptr_h, ptr_l[3:1], 1'b0};
        pair_d = 1'b1;
      end
      `DMBA_MODE_FMEM: begin
        addr_d = {`DMBA_BANK_HIGH, operand};
        err_d = !((operand[7:4] == `DMBA_FMEM_INTR) ||
                  (operand[7:4] == `DMBA_FMEM_PORT));
      end
      `DMBA_MODE_PMEM: begin
        addr_d = {`DMBA_BANK_HIGH, operand[7:2], ptr_l[3:2]};
        bit_d = ptr_l[1:0];
        err_d = (operand[7:6] != 2'h3);
      end
      `DMBA_MODE_HMEM: begin
        addr_d = {bank_and, ptr_h, operand[3:0]};
      end
      `DMBA_MODE_STACK: begin
        // only the two lowest banks can hold the stack
        addr_d = {3'h0, stack_bank_select_q, stack_ptr};
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  // access outputs, presented in the cycle after the request
  always @(posedge sys_clk) begin
    if (rst) begin
      mem_addr_q <= 12'h000;
      bit_sel_q <= 2'h0;
      addr_valid_q <= 1'b0;
      pair_access_q <= 1'b0;
      ram_sel_q <= 1'b0;
      periph_sel_q <= 1'b0;
      mode_err_q <= 1'b0;
      ptr_l_wr_q <= 1'b0;
      ptr_l_next_q <= 4'h0;
    end else begin
      addr_valid_q <= req_valid;
      mode_err_q <= req_valid && err_d;
      // pointer update only once the access itself is issued
      ptr_l_wr_q <= req_valid && ptr_wr_d && !err_d;
      if (req_valid) begin
        mem_addr_q <= addr_d;
        bit_sel_q <= bit_d;
        pair_access_q <= pair_d;
        ptr_l_next_q <= ptr_next_d;
        ram_sel_q <= addr_in_ram;
        periph_sel_q <= addr_in_periph;
      end else begin
        // selects stand only in the cycle of a valid access
        ram_sel_q <= 1'b0;
        periph_sel_q <= 1'b0;
      end
    end
  end

  // flag save stack: top of stack is the highest occupied slot
  always @* begin
    bef_pop = 1'b0;
    if (!save_empty) begin
      bef_pop = save_stack_q[save_cnt_q[SAVE_AW-1:0] - 1'b1];
    end
  end

  always @* begin
    bef_d = bank_enable_flag_q;
    if (intr_enter) begin
      // the handler's own flag must be in place for its first access
      bef_d = intr_vector_bef;
    end else if (call_enter) begin
      bef_d = bank_enable_flag_q;
    end else if (call_return || intr_return) begin
      // a return with nothing saved keeps the flag and flags underflow
      bef_d = save_empty ? bank_enable_flag_q : bef_pop;
    end else if (bank_enable_set) begin
      bef_d = 1'b1;
    end else if (bank_enable_clr) begin
      bef_d = 1'b0;
    end else if (ctrl_wr) begin
      // software loses to any decoder event in the same cycle
      bef_d = reg_wdata[`DMBA_CTRL_BEF];
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      bank_enable_flag_q <= `DMBA_RST_BEF;
      save_stack_q <= {SAVE_DEPTH{1'b0}};
      save_cnt_q <= {(SAVE_AW+1){1'b0}};
      save_ovf_q <= 1'b0;
      save_unf_q <= 1'b0;
    end else begin
      bank_enable_flag_q <= bef_d;
      if (intr_enter || call_enter) begin
        // a push into a full stack is dropped and flags overflow
        if (save_full) begin
          save_ovf_q <= 1'b1;
        end else begin
          save_stack_q[save_cnt_q[SAVE_AW-1:0]] <= bank_enable_flag_q;
          save_cnt_q <= save_cnt_q + 1'b1;
        end
      end else if (call_return || intr_return) begin
        if (save_empty) begin
          save_unf_q <= 1'b1;
        end else begin
          save_cnt_q <= save_cnt_q - 1'b1;
        end
      end else if (ctrl_wr) begin
        if (sticky_clr) begin
          save_ovf_q <= 1'b0;
          save_unf_q <= 1'b0;
        end
      end
    end
  end

  // bank select is not saved by hardware; software pushes it
  always @(posedge sys_clk) begin
    if (rst) begin
      bank_select_reg_q <= `DMBA_RST_BSEL;
      stack_bank_select_q <= `DMBA_RST_STK_BANK;
    end else begin
      if (bank_sel_wr) begin
        if (bsel_ok) begin
          bank_select_reg_q <= bank_sel_val;
        end
      end else if (ctrl_wr && sw_bsel_ok) begin
        bank_select_reg_q <= sw_bsel;
      end
      if (ctrl_wr) begin
        stack_bank_select_q <= reg_wdata[`DMBA_CTRL_STK_BANK];
      end
    end
  end

  // sticky error, set wins over a clearing write in the same cycle
  always @(posedge sys_clk) begin
    if (rst) begin
      err_seen_q <= 1'b0;
    end else if (req_valid && err_d) begin
      err_seen_q <= 1'b1;
    end else if (status_wr && reg_wdata[0]) begin
      err_seen_q <= 1'b0;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      // read data stands one cycle only and is zero otherwise
      case (reg_addr)
        `DMBA_OFS_CTRL: begin
          reg_rdata <= ctrl_word;
        end
        `DMBA_OFS_STATUS: begin
          reg_rdata <= status_word;
        end
        `DMBA_OFS_LAST: begin
          reg_rdata <= {20'h0, mem_addr_q};
        end
        default: begin
          reg_rdata <= 32'h00000000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

endmodule // dmba_addr_gen

/* File: bench/dmba_mem_model.sv */
`timescale 1ns/1ps
module dmba_mem_model (
  input wire [11:0] addr,
  input wire valid,
  output logic ram_hit,
  output logic periph_hit
);
  // far side decode: only the ram and the peripheral area answer
  assign ram_hit = valid && addr <= 12'h0FF;
  assign periph_hit = valid && addr >= 12'hF80;
endmodule // dmba_mem_model

/* File: bench/dmba_addr_gen_monitor.sv */
`timescale 1ns/1ps
module dmba_monitor (
  input wire sys_clk,
  input wire rst,
  input wire req_valid,
  input wire [3:0] req_mode,
  input wire [7:0] operand,
  input wire [3:0] ptr_l,
  input wire [11:0] mem_addr_q,
  input wire addr_valid_q,
  input wire ram_sel_q,
  input wire mode_err_q,
  input wire ptr_l_wr_q,
  input wire [3:0] ptr_l_next_q,
  input wire bank_enable_flag_q,
  input wire [3:0] bank_select_reg_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire dir_req = req_valid && req_mode <= 4'h2;
  wire [3:0] bsel = bank_select_reg_q;
  a_valid_next: assert property (
    req_valid |=> addr_valid_q) else $error("no address");
  a_ram_decode: assert property (
    addr_valid_q && !mode_err_q |-> ram_sel_q == (mem_addr_q <= 12'h0FF))
    else $error("ram decode");
  a_bank_legal: assert property (
    bsel == 4'h0 || bsel == 4'hF) else $error("bad bank");
  a_dir_select: assert property (
    dir_req && bank_enable_flag_q |=> mem_addr_q[11:8] == $past(bsel))
    else $error("direct bank");
  a_dir_fixed: assert property (
    dir_req && !bank_enable_flag_q
    |=> mem_addr_q[11:8] == {4{$past(operand) >= 8'h80}})
    else $error("fixed bank");
  a_main_and: assert property (
    req_valid && req_mode == 4'h3
    |=> mem_addr_q[11:8] == ($past(bsel) & {4{$past(bank_enable_flag_q)}}))
    else $error("main pair bank");
  a_post_inc: assert property (
    req_valid && req_mode == 4'h4
    |=> mode_err_q || ptr_l_wr_q && ptr_l_next_q == $past(ptr_l) + 4'h1)
    else $error("post increment");
  a_alt_bank: assert property (
    req_valid && (req_mode == 4'h6 || req_mode == 4'h7)
    |=> mem_addr_q[11:8] == 4'h0) else $error("alt bank");
  c_post_inc: cover property (req_valid && req_mode == 4'h4);
  c_error: cover property (mode_err_q);
  c_ram: cover property (ram_sel_q);
endmodule // dmba_monitor

bind dmba_addr_gen dmba_monitor i_mon (.sys_clk, .rst, .req_valid,
  .req_mode, .operand, .ptr_l, .mem_addr_q, .addr_valid_q, .ram_sel_q,
  .mode_err_q, .ptr_l_wr_q, .ptr_l_next_q, .bank_enable_flag_q,
  .bank_select_reg_q);

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [3:0] mode, cls, fl, sel;
    logic [7:0] op;
    logic [3:0] h, l, err;
    logic [11:0] exp;
  } dmba_row_t;
  dmba_row_t rows [24];
  dmba_row_t r;
  logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, req_valid = 0;
  logic bank_enable_set = 0, bank_enable_clr = 0, bank_sel_wr = 0;
  logic [4:0] ev = 0;
  logic [3:0] reg_addr = 0, req_mode = 0, req_class = 0;
  logic [1:0] bit_sel_q;
  logic [3:0] ptr_h = 0, ptr_l = 0, bank_sel_val = 0, ptr_l_next_q;
  logic [3:0] bank_select_reg_q;
  logic [7:0] operand = 0;
  logic [31:0] reg_wdata = 0, reg_rdata;
  logic [11:0] mem_addr_q;
  logic addr_valid_q, pair_access_q, ram_sel_q, periph_sel_q, mode_err_q;
  logic ptr_l_wr_q, bank_enable_flag_q, periph_hit, ram_hit;
  int n_mismatch = 0, n_checks = 0;
  dmba_addr_gen i_dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .req_valid, .req_mode, .req_class, .operand,
    .bit_idx(2'h1), .ptr_h, .ptr_l, .ptr_d(4'h5), .ptr_e(4'h7),
    .stack_ptr(8'h34), .bank_enable_set, .bank_enable_clr, .bank_sel_wr,
    .bank_sel_val, .call_enter(ev[0]), .call_return(ev[1]),
    .intr_enter(ev[2]), .intr_vector_bef(ev[4]), .intr_return(ev[3]),
    .mem_addr_q, .bit_sel_q, .addr_valid_q, .pair_access_q, .ram_sel_q,
    .periph_sel_q, .mode_err_q, .ptr_l_wr_q, .ptr_l_next_q,
    .bank_enable_flag_q, .bank_select_reg_q);
  dmba_mem_model i_mem (.addr(mem_addr_q), .valid(addr_valid_q),
    .ram_hit, .periph_hit);
  initial forever #2.5 sys_clk = !sys_clk;
  task automatic chk_val(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_addr(input logic [11:0] got, exp);
    chk_val({20'h0, got}, {20'h0, exp});
  endtask
  task automatic end_sim;
    if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge sys_clk);
    reg_wr <= 0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge sys_clk);
    reg_rd <= 0;
    #1 chk_val(reg_rdata, e);
  endtask
  // flag and select are set together, as software would before an access
  task automatic setbank(input logic f, input logic [3:0] s);
    @(posedge sys_clk);
    bank_enable_set <= f;
    bank_enable_clr <= !f;
    bank_sel_wr <= 1;
    bank_sel_val <= s;
    @(posedge sys_clk);
    bank_enable_set <= 0;
    bank_enable_clr <= 0;
    bank_sel_wr <= 0;
    #1;
  endtask
  task automatic ev_pulse(input logic [4:0] e);
    @(posedge sys_clk);
    ev <= e;
    @(posedge sys_clk);
    ev <= 4'h0;
    #1;
  endtask
  task automatic req(input logic [3:0] m, c, input logic [7:0] o,
                     input logic [3:0] h, l);
    @(posedge sys_clk);
    req_valid <= 1;
    req_mode <= m;
    req_class <= c;
    operand <= o;
    ptr_h <= h;
    ptr_l <= l;
    @(posedge sys_clk);
    req_valid <= 0;
    #1 chk_val(addr_valid_q, 1);
  endtask
  initial begin
    // mode cls flag sel operand h l err address
    rows = '{48'h1_0_0_F_5F_0_0_0_05F, 48'h1_4_0_F_90_0_0_0_F90,
      48'h1_3_1_F_20_0_0_0_F20, 48'h1_1_1_0_A7_0_0_0_0A7,
      48'h1_2_0_0_7F_0_0_0_07F, 48'h0_5_1_0_A7_0_0_0_0A7,
      48'h0_6_0_0_87_0_0_0_F87, 48'h0_7_1_F_3F_0_0_0_F3F,
      48'h0_8_0_F_3F_0_0_0_03F, 48'h0_0_0_F_3F_0_0_1_03F,
      48'h2_0_1_F_20_0_0_0_F20, 48'h2_0_0_F_21_0_0_1_020,
      48'h3_0_0_F_00_1_7_0_017, 48'h3_0_1_F_00_1_7_0_F17,
      48'h5_0_1_F_00_2_0_0_F20, 48'h6_0_1_F_00_0_0_0_057,
      48'h7_0_1_F_00_0_9_0_059, 48'h8_0_1_F_00_3_1_0_F30,
      48'h9_5_0_0_B3_0_0_0_FB3, 48'h9_5_1_0_F2_0_0_0_FF2,
      48'h9_5_1_0_80_0_0_1_000, 48'hA_5_1_0_C4_0_6_0_FC5,
      48'hB_5_1_F_2A_3_0_0_F3A, 48'hC_0_1_F_00_0_0_0_034};
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    rd(4'h0, 32'h0);
    foreach (rows[i]) begin
      r = rows[i];
      setbank(r.fl[0], r.sel);
      req(r.mode, r.cls, r.op, r.h, r.l);
      chk_val(mode_err_q, r.err[0]);
      if (!r.err[0]) begin
        chk_addr(mem_addr_q, r.exp);
        chk_val(ram_sel_q, r.exp <= 12'h0FF);
        chk_val(periph_hit, r.exp >= 12'hF80);
        chk_val(pair_access_q, r.mode == 4'h2 || r.mode == 4'h8);
        chk_val(periph_sel_q, r.exp >= 12'hF80);
        chk_val(ram_hit, r.exp <= 12'h0FF);
        chk_val(bit_sel_q, r.mode == 4'hA ? r.l[1:0] : 2'h1);
      end
    end
    setbank(1'b1, 4'hF);
    setbank(1'b1, 4'h3);
    chk_val(bank_select_reg_q, 4'hF);
    wr(4'h0, 32'h51);
    rd(4'h0, 32'hF1);
    wr(4'h0, 32'h1F1);
    req(4'hC, 4'h0, 8'h00, 4'h0, 4'h0);
    chk_addr(mem_addr_q, 12'h134);
    rd(4'h8, 32'h134);
    rd(4'hC, 32'h0);
    req(4'h4, 4'h0, 8'h00, 4'h1, 4'hF);
    chk_val(ptr_l_wr_q, 1);
    chk_val(ptr_l_next_q, 4'h0);
    req(4'h5, 4'h0, 8'h00, 4'h1, 4'h0);
    chk_val(ptr_l_next_q, 4'hF);
    ev_pulse(4'h1);
    setbank(1'b0, 4'h0);
    ev_pulse(4'h2);
    chk_val(bank_enable_flag_q, 1);
    chk_val(bank_select_reg_q, 4'h0);
    setbank(1'b0, 4'hF);
    ev_pulse(5'h14);
    chk_val(bank_enable_flag_q, 1);
    ev_pulse(4'h8);
    chk_val(bank_enable_flag_q, 0);
    setbank(1'b1, 4'hF);
    ev_pulse(5'h04);
    chk_val(bank_enable_flag_q, 0);
    ev_pulse(5'h08);
    chk_val(bank_enable_flag_q, 1);
    rd(4'h4, 32'h1);
    ev_pulse(5'h02);
    chk_val(bank_enable_flag_q, 1);
    repeat (9) ev_pulse(5'h01);
    rd(4'h4, 32'h807);
    wr(4'h4, 32'h1);
    wr(4'h0, 32'h2F1);
    rd(4'h4, 32'h800);
    end_sim;
  end
endmodule // testbench
